// [src/lpic_pkg.sv]
// Constants, types and helpers shared by the legacy interrupt controller and its redirection entry.
package lpic_pkg;

  // ****************************************
  // Memory-mapped entry field positions
  // ****************************************
  localparam int IE_DEST_LSB = 56;
  localparam int IE_XDEST_LSB = 32;
  localparam int IE_MASK_BIT = 16;
  localparam int IE_LEVEL_BIT = 15;
  localparam int IE_WAIT_BIT = 14;
  localparam int IE_POL_BIT = 13;
  localparam int IE_DMODE_BIT = 11;
  localparam int IE_TYPE_LSB = 8;
  localparam int IE_VEC_LSB = 0;

  // ****************************************
  // Configuration interrupt field positions
  // ****************************************
  localparam int II_TYPE_TOP_BIT = 7;
  localparam int II_DMODE_BIT = 6;
  localparam int II_LEVEL_BIT = 5;
  localparam int II_TYPE_LSB = 2;
  localparam int II_DEST_LSB = 8;
  localparam int II_VEC_LSB = 16;
  localparam int II_XADDR_LSB = 24;
  localparam int II_XDEST_LSB = 32;

  // ****************************************
  // Widths and reset values
  // ****************************************
  localparam int VEC_W = 8;
  localparam int DEST_W = 8;
  localparam int XDEST_W = 24;
  localparam int REPLY_W = 32;
  localparam logic [63:0] INFO_RST = 64'h0000000000000000;
  localparam logic MASK_RST = 1'b1;
  localparam logic POL_RST = 1'b0;

  // ****************************************
  // Message type codes
  // ****************************************
  localparam logic [2:0] TYPE_REG_RSV3 = 3'h3;
  localparam logic [2:0] TYPE_REG_NMI = 3'h4;
  localparam logic [2:0] TYPE_REG_INIT = 3'h5;
  localparam logic [2:0] TYPE_REG_RSV6 = 3'h6;
  localparam logic [2:0] TYPE_REG_EXTERNAL = 3'h7;
  localparam logic [3:0] TYPE_LINK_NMI = 4'h3;
  localparam logic [3:0] TYPE_LINK_INIT = 4'h4;
  localparam logic [3:0] TYPE_LINK_EXTERNAL = 4'h6;

  typedef enum logic [1:0] {
    LEG_IDLE = 2'b00,
    LEG_WAIT_ACK = 2'b01,
    LEG_SERVICE = 2'b10
  } lpic_leg_state_type;

  // Register code to link code; the top bit comes from configuration space.
  function automatic logic [3:0] lpic_type_to_link(input logic hi_bit, input logic [2:0] code);
    logic [3:0] res;
    res = {hi_bit, code};
    case (code)
      TYPE_REG_NMI: res = {hi_bit, TYPE_LINK_NMI[2:0]};
      TYPE_REG_INIT: res = {hi_bit, TYPE_LINK_INIT[2:0]};
      TYPE_REG_EXTERNAL: res = {hi_bit, TYPE_LINK_EXTERNAL[2:0]};
      default: res = {hi_bit, code};
    endcase
    return res;
  endfunction

endpackage

// [src/lpic_redir_entry.sv]
// Redirection entry storage with its configuration-space and memory-mapped views.
`timescale 1ns/1ps
`default_nettype none
module lpic_redir_entry import lpic_pkg::*; #(
  parameter bit EXT_DEST_EN = 1'b1
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic cfg_wr,
  input wire logic [63:0] cfg_wdata,
  output logic [63:0] cfg_rdata,
  input wire logic mm_wr,
  input wire logic mm_rd,
  input wire logic mm_hi,
  input wire logic [31:0] mm_wdata,
  output logic [31:0] mm_rdata,
  input wire logic waiting,
  output logic [63:0] info,
  output logic mask,
  output logic polarity
);

  logic [63:0] info_q;
  logic [63:0] info_d;
  logic mask_q;
  logic mask_d;
  logic pol_q;
  logic pol_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [31:0] view_lo;
  logic [31:0] view_hi;

  // ****************************************
  // Views and next values
  // ****************************************
  always_comb begin
    view_lo = 32'h00000000;
    view_lo[IE_VEC_LSB +: VEC_W] = info_q[II_VEC_LSB +: VEC_W];
    view_lo[IE_TYPE_LSB +: 3] = info_q[II_TYPE_LSB +: 3];
    view_lo[IE_DMODE_BIT] = info_q[II_DMODE_BIT];
    view_lo[IE_POL_BIT] = pol_q;
    view_lo[IE_WAIT_BIT] = waiting;
    view_lo[IE_LEVEL_BIT] = info_q[II_LEVEL_BIT];
    view_lo[IE_MASK_BIT] = mask_q;
    view_hi = {info_q[II_DEST_LSB +: DEST_W], info_q[II_XDEST_LSB +: XDEST_W]};
    info_d = info_q;
    mask_d = mask_q;
    pol_d = pol_q;
    if (cfg_wr) begin
      info_d = cfg_wdata;
    end
    if (mm_wr && !mm_hi) begin
      info_d[II_VEC_LSB +: VEC_W] = mm_wdata[IE_VEC_LSB +: VEC_W];
      info_d[II_TYPE_LSB +: 3] = mm_wdata[IE_TYPE_LSB +: 3];
      info_d[II_DMODE_BIT] = mm_wdata[IE_DMODE_BIT];
      info_d[II_LEVEL_BIT] = mm_wdata[IE_LEVEL_BIT];
      mask_d = mm_wdata[IE_MASK_BIT];
      pol_d = mm_wdata[IE_POL_BIT];
    end
    if (mm_wr && mm_hi) begin
      info_d[II_DEST_LSB +: DEST_W] = mm_wdata[IE_DEST_LSB - 32 +: DEST_W];
      info_d[II_XDEST_LSB +: XDEST_W] = mm_wdata[IE_XDEST_LSB - 32 +: XDEST_W];
    end
    if (!EXT_DEST_EN) begin
      info_d[II_XDEST_LSB +: XDEST_W] = 24'h000000;
    end
    rdata_d = rdata_q;
    if (mm_rd) begin
      rdata_d = mm_hi ? view_hi : view_lo;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      info_q <= INFO_RST;
      mask_q <= MASK_RST;
      pol_q <= POL_RST;
      rdata_q <= 32'h00000000;
    end else begin
      info_q <= info_d;
      mask_q <= mask_d;
      pol_q <= pol_d;
      rdata_q <= rdata_d;
    end
  end

  assign cfg_rdata = info_q;
  assign mm_rdata = rdata_q;
  assign info = info_q;
  assign mask = mask_q;
  assign polarity = pol_q;

endmodule
`default_nettype wire

// [src/lpic_top.sv]
// Legacy interrupt controller flow and redirection-entry request source facing the link.
`timescale 1ns/1ps
`default_nettype none
module lpic_top import lpic_pkg::*; #(
  parameter int NUM_LEGACY = 8,
  parameter bit EXT_DEST_EN = 1'b1
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic link_clk,
  input wire logic [NUM_LEGACY-1:0] leg_irq,
  input wire logic [7:0] leg_vector_base,
  input wire logic [7:0] leg_dest,
  input wire logic ext_irq,
  input wire logic interrupt_acknowledge_read_valid,
  input wire logic interrupt_acknowledge_read_compat,
  input wire logic [3:0] interrupt_acknowledge_read_byte_mask,
  input wire logic eoi_valid,
  input wire logic [7:0] eoi_vector,
  input wire logic io_eoi_valid,
  output logic read_reply_valid,
  output logic [31:0] read_reply_data,
  output logic req_valid,
  output logic [3:0] req_msg_type,
  output logic req_level,
  output logic req_dest_mode,
  output logic [31:0] req_dest,
  output logic [7:0] req_vector,
  output logic [7:0] req_ext_addr,
  input wire logic cfg_wr,
  input wire logic [63:0] cfg_wdata,
  output logic [63:0] cfg_rdata,
  input wire logic mm_wr,
  input wire logic mm_rd,
  input wire logic mm_hi,
  input wire logic [31:0] mm_wdata,
  output logic [31:0] mm_rdata
);

  if (NUM_LEGACY < 1 || NUM_LEGACY > 8) begin : g_chk
    $error("NUM_LEGACY must be between 1 and 8");
  end

  localparam int SYNC_W = NUM_LEGACY + 14;

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [SYNC_W-1:0] sync_in;
  logic [SYNC_W-1:0] s1_q;
  logic [SYNC_W-1:0] s2_q;
  logic lclk_prev_q;
  logic s_lclk;
  logic [NUM_LEGACY-1:0] s_leg;
  logic s_ext;
  logic s_interrupt_acknowledge_read;
  logic s_compat;
  logic s_eoi;
  logic [7:0] s_eoi_vec;
  logic s_io_eoi;
  logic lclk_rise;
  logic lclk_fall;

  // The byte mask of an acknowledge read has no effect on the answer.
  assign sync_in = {link_clk, leg_irq, ext_irq, interrupt_acknowledge_read_valid, interrupt_acknowledge_read_compat, eoi_valid, eoi_vector, io_eoi_valid};
  assign {s_lclk, s_leg, s_ext, s_interrupt_acknowledge_read, s_compat, s_eoi, s_eoi_vec, s_io_eoi} = s2_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      s1_q <= '0;
      s2_q <= '0;
      lclk_prev_q <= 1'b0;
    end else begin
      s1_q <= sync_in;
      s2_q <= s1_q;
      lclk_prev_q <= s_lclk;
    end
  end

  // Link strobes are captured on the falling link edge, mid-way through their period.
  assign lclk_rise = s_lclk & ~lclk_prev_q;
  assign lclk_fall = ~s_lclk & lclk_prev_q;

  logic interrupt_acknowledge_read_take;
  logic eoi_take;
  logic io_eoi_take;

  assign interrupt_acknowledge_read_take = lclk_fall & s_interrupt_acknowledge_read & s_compat;
  assign eoi_take = lclk_fall & s_eoi;
  assign io_eoi_take = lclk_fall & s_io_eoi;

  // ****************************************
  // Redirection entry
  // ****************************************
  logic wait_q;
  logic wait_d;
  logic [63:0] info;
  logic ent_mask;
  logic ent_pol;

  lpic_redir_entry #(
    .EXT_DEST_EN(EXT_DEST_EN)
  ) u_entry (
    .clk(clk),
    .srst(srst),
    .cfg_wr(cfg_wr),
    .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata),
    .mm_wr(mm_wr),
    .mm_rd(mm_rd),
    .mm_hi(mm_hi),
    .mm_wdata(mm_wdata),
    .mm_rdata(mm_rdata),
    .waiting(wait_q),
    .info(info),
    .mask(ent_mask),
    .polarity(ent_pol)
  );

  logic [2:0] ent_type;
  logic ent_level;
  logic ent_legal;

  assign ent_type = info[II_TYPE_LSB +: 3];
  assign ent_level = info[II_LEVEL_BIT];
  assign ent_legal = (ent_type != TYPE_REG_RSV3) && (ent_type != TYPE_REG_RSV6);

  // ****************************************
  // Legacy controller state
  // ****************************************
  lpic_leg_state_type leg_state_q;
  lpic_leg_state_type leg_state_d;
  logic [NUM_LEGACY-1:0] leg_prev_q;
  logic [NUM_LEGACY-1:0] leg_pend_q;
  logic [NUM_LEGACY-1:0] leg_pend_d;
  logic [NUM_LEGACY-1:0] leg_isr_q;
  logic [NUM_LEGACY-1:0] leg_isr_d;
  logic leg_send_q;
  logic leg_send_d;
  logic rep_send_q;
  logic rep_send_d;
  logic [7:0] rep_vec_q;
  logic [7:0] rep_vec_d;
  logic [7:0] act_vec;
  logic [NUM_LEGACY-1:0] act_onehot;
  logic leg_launch;

  // Lowest line number has the highest priority; none pending answers base with its low three bits set to seven.
  always_comb begin
    act_vec = leg_vector_base | 8'h07;
    act_onehot = '0;
    for (int i = NUM_LEGACY - 1; i >= 0; i--) begin
      if (leg_pend_q[i]) begin
        act_vec = leg_vector_base + 8'(i);
        act_onehot = '0;
        act_onehot[i] = 1'b1;
      end
    end
  end

  always_comb begin
    leg_state_d = leg_state_q;
    leg_isr_d = leg_isr_q;
    leg_send_d = leg_send_q & ~leg_launch;
    rep_send_d = rep_send_q & ~(lclk_rise & rep_send_q);
    rep_vec_d = rep_vec_q;
    leg_pend_d = leg_pend_q;
    if (interrupt_acknowledge_read_take) begin
      rep_vec_d = act_vec;
      rep_send_d = 1'b1;
      leg_pend_d = leg_pend_q & ~act_onehot;
      leg_isr_d = leg_isr_q | act_onehot;
      leg_state_d = LEG_SERVICE;
    end
    // New edges are never lost to a clear in the same cycle.
    leg_pend_d = leg_pend_d | (s_leg & ~leg_prev_q);
    unique case (leg_state_q)
      LEG_IDLE: begin
        if (|leg_pend_q && !interrupt_acknowledge_read_take) begin
          leg_send_d = 1'b1;
          leg_state_d = LEG_WAIT_ACK;
        end
      end
      LEG_WAIT_ACK: begin
      end
      LEG_SERVICE: begin
        if (io_eoi_take) begin
          leg_isr_d = '0;
          leg_state_d = LEG_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      leg_state_q <= LEG_IDLE;
      leg_prev_q <= '0;
      leg_pend_q <= '0;
      leg_isr_q <= '0;
      leg_send_q <= 1'b0;
      rep_send_q <= 1'b0;
      rep_vec_q <= 8'h00;
    end else begin
      leg_state_q <= leg_state_d;
      leg_prev_q <= s_leg;
      leg_pend_q <= leg_pend_d;
      leg_isr_q <= leg_isr_d;
      leg_send_q <= leg_send_d;
      rep_send_q <= rep_send_d;
      rep_vec_q <= rep_vec_d;
    end
  end

  // ****************************************
  // Entry source
  // ****************************************
  logic ent_prev_q;
  logic ent_active;
  logic ent_send_q;
  logic ent_send_d;
  logic ent_fire;
  logic ent_launch;

  assign ent_active = s_ext ^ ent_pol;

  assign ent_fire = !ent_mask && ent_legal && !ent_send_q &&
                    (ent_level ? (ent_active && !wait_q) : (ent_active && !ent_prev_q));

  always_comb begin
    ent_send_d = (ent_send_q & ~ent_launch & ~ent_mask) | ent_fire;
    wait_d = wait_q;
    if (eoi_take && (s_eoi_vec == info[II_VEC_LSB +: VEC_W])) begin
      wait_d = 1'b0;
    end
    if (ent_launch && ent_level) begin
      wait_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ent_prev_q <= 1'b0;
      ent_send_q <= 1'b0;
      wait_q <= 1'b0;
    end else begin
      ent_prev_q <= ent_active;
      ent_send_q <= ent_send_d;
      wait_q <= wait_d;
    end
  end

  // ****************************************
  // Link outputs
  // ****************************************
  logic req_valid_q;
  logic req_valid_d;
  logic [3:0] req_type_q;
  logic [3:0] req_type_d;
  logic req_level_q;
  logic req_level_d;
  logic req_dmode_q;
  logic req_dmode_d;
  logic [31:0] req_dest_q;
  logic [31:0] req_dest_d;
  logic [7:0] req_vec_q;
  logic [7:0] req_vec_d;
  logic [7:0] req_xaddr_q;
  logic [7:0] req_xaddr_d;
  logic rep_valid_q;
  logic rep_valid_d;
  logic [31:0] rep_data_q;
  logic [31:0] rep_data_d;

  // The legacy controller wins the link when both sources are ready.
  assign leg_launch = lclk_rise & leg_send_q;
  assign ent_launch = lclk_rise & ent_send_q & ~leg_send_q & ~ent_mask;

  always_comb begin
    req_valid_d = req_valid_q;
    req_type_d = req_type_q;
    req_level_d = req_level_q;
    req_dmode_d = req_dmode_q;
    req_dest_d = req_dest_q;
    req_vec_d = req_vec_q;
    req_xaddr_d = info[II_XADDR_LSB +: 8];
    rep_valid_d = rep_valid_q;
    rep_data_d = rep_data_q;
    if (lclk_rise) begin
      req_valid_d = 1'b0;
      rep_valid_d = 1'b0;
      if (leg_launch) begin
        req_valid_d = 1'b1;
        req_type_d = TYPE_LINK_EXTERNAL;
        req_level_d = 1'b0;
        req_dmode_d = 1'b0;
        req_dest_d = {24'h000000, leg_dest};
        req_vec_d = 8'h00;
      end else if (ent_launch) begin
        req_valid_d = 1'b1;
        req_type_d = lpic_type_to_link(info[II_TYPE_TOP_BIT], ent_type);
        req_level_d = ent_level;
        req_dmode_d = info[II_DMODE_BIT];
        req_dest_d = {info[II_XDEST_LSB +: XDEST_W], info[II_DEST_LSB +: DEST_W]};
        req_vec_d = info[II_VEC_LSB +: VEC_W];
      end
      if (rep_send_q) begin
        rep_valid_d = 1'b1;
        rep_data_d = {24'h000000, rep_vec_q};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      req_valid_q <= 1'b0;
      req_type_q <= 4'h0;
      req_level_q <= 1'b0;
      req_dmode_q <= 1'b0;
      req_dest_q <= 32'h00000000;
      req_vec_q <= 8'h00;
      req_xaddr_q <= 8'h00;
      rep_valid_q <= 1'b0;
      rep_data_q <= 32'h00000000;
    end else begin
      req_valid_q <= req_valid_d;
      req_type_q <= req_type_d;
      req_level_q <= req_level_d;
      req_dmode_q <= req_dmode_d;
      req_dest_q <= req_dest_d;
      req_vec_q <= req_vec_d;
      req_xaddr_q <= req_xaddr_d;
      rep_valid_q <= rep_valid_d;
      rep_data_q <= rep_data_d;
    end
  end

  assign req_valid = req_valid_q;
  assign req_msg_type = req_type_q;
  assign req_level = req_level_q;
  assign req_dest_mode = req_dmode_q;
  assign req_dest = req_dest_q;
  assign req_vector = req_vec_q;
  assign req_ext_addr = req_xaddr_q;
  assign read_reply_valid = rep_valid_q;
  assign read_reply_data = rep_data_q;

endmodule
`default_nettype wire

// [verif/lpic_top_assertions.sv]
// Concurrent checks on the ports of the legacy interrupt controller top level.
`timescale 1ns/1ps
`default_nettype none
module lpic_top_assertions #(
  parameter bit EXT_DEST_EN = 1'b1
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic interrupt_acknowledge_read_valid,
  input wire logic interrupt_acknowledge_read_compat,
  input wire logic read_reply_valid,
  input wire logic [31:0] read_reply_data,
  input wire logic req_valid,
  input wire logic [3:0] req_msg_type,
  input wire logic req_level,
  input wire logic cfg_wr,
  input wire logic [63:0] cfg_wdata,
  input wire logic [63:0] cfg_rdata,
  input wire logic mm_wr,
  input wire logic mm_rd,
  input wire logic mm_hi,
  input wire logic [31:0] mm_wdata,
  input wire logic [31:0] mm_rdata
);
  default clocking dcb @(posedge clk); endclocking
  default disable iff (srst);

  AST_REPLY_HI_ZERO: assert property (read_reply_valid |-> read_reply_data[31:8] == 24'h0)
    else $error("reply upper bits not zero");
  AST_REQ_STANDS: assert property ($rose(req_valid) |-> req_valid [*7])
    else $error("request dropped early");
  AST_LEG_EDGE: assert property (req_valid && req_msg_type == 4'h6 |-> !req_level)
    else $error("external request not edge mode");
  AST_TYPE_XLATE: assert property (req_valid |-> req_msg_type[2:0] != 3'h5 && req_msg_type[2:0] != 3'h7)
    else $error("request carries untranslated type");
  AST_ACK_REPLY: assert property ($rose(interrupt_acknowledge_read_valid) && interrupt_acknowledge_read_compat |-> ##[1:24] $rose(read_reply_valid))
    else $error("acknowledge not answered");
  AST_LOW_RSV: assert property ($past(mm_rd) && !$past(mm_hi) |-> mm_rdata[31:17] == 15'h0 && !mm_rdata[12])
    else $error("reserved bits read nonzero");
  AST_RDATA_HOLD: assert property (!$past(mm_rd) && !$past(srst) |-> $stable(mm_rdata))
    else $error("read data changed without read");
  AST_CFG_WRITE: assert property ($past(cfg_wr) && !$past(mm_wr) && !$past(srst)
    |-> cfg_rdata[31:0] == $past(cfg_wdata[31:0]))
    else $error("configuration write lost");
  AST_LOW_ALIAS: assert property ($past(mm_wr) && !$past(mm_hi) && !$past(srst) |->
    cfg_rdata[23:16] == $past(mm_wdata[7:0]) && cfg_rdata[4:2] == $past(mm_wdata[10:8]) &&
    cfg_rdata[6] == $past(mm_wdata[11]) && cfg_rdata[5] == $past(mm_wdata[15]))
    else $error("low word alias mismatch");
  AST_HI_ALIAS: assert property ($past(mm_wr) && $past(mm_hi) && !$past(srst) |->
    cfg_rdata[15:8] == $past(mm_wdata[31:24]) &&
    cfg_rdata[55:32] == (EXT_DEST_EN ? $past(mm_wdata[23:0]) : 24'h0))
    else $error("high word alias mismatch");
endmodule

bind lpic_top lpic_top_assertions #(.EXT_DEST_EN(EXT_DEST_EN)) i_lpic_chk (
  .clk, .srst, .interrupt_acknowledge_read_valid, .interrupt_acknowledge_read_compat, .read_reply_valid, .read_reply_data, .req_valid, .req_msg_type,
  .req_level, .cfg_wr, .cfg_wdata, .cfg_rdata, .mm_wr, .mm_rd, .mm_hi, .mm_wdata, .mm_rdata);
`default_nettype wire

// [verif/lpic_host_model.sv]
// Host bridge model: link clock, acknowledge reads, I/O end-of-interrupt and returned EOI.
`timescale 1ns/1ps
`default_nettype none
module lpic_host_model (
  input wire logic auto_en,
  input wire logic req_valid,
  input wire logic [3:0] req_msg_type,
  input wire logic req_level,
  input wire logic [7:0] req_vector,
  input wire logic read_reply_valid,
  output logic link_clk,
  output logic interrupt_acknowledge_read_valid,
  output logic interrupt_acknowledge_read_compat,
  output logic [3:0] interrupt_acknowledge_read_byte_mask,
  output logic eoi_valid,
  output logic [7:0] eoi_vector,
  output logic io_eoi_valid
);
  logic ack_pend = 1'b0;
  logic io_pend = 1'b0;
  logic eoi_pend = 1'b0;
  logic [7:0] eoi_vec = 8'h00;

  initial begin
    link_clk = 1'b0;
    {interrupt_acknowledge_read_valid, interrupt_acknowledge_read_compat, eoi_valid, io_eoi_valid} = 4'h0;
    interrupt_acknowledge_read_byte_mask = 4'h0;
    eoi_vector = 8'h00;
  end
  always #160 link_clk = ~link_clk;

  // Requests are latched even while stalled; clearing auto_en holds back every acknowledge read and EOI.
  always @(posedge link_clk) begin
    interrupt_acknowledge_read_valid <= 1'b0;
    interrupt_acknowledge_read_compat <= 1'b0;
    eoi_valid <= 1'b0;
    io_eoi_valid <= 1'b0;
    eoi_vector <= ~eoi_vector;
    if (req_valid && req_msg_type == 4'h6) ack_pend <= 1'b1;
    if (req_valid && req_level) begin
      eoi_pend <= 1'b1;
      eoi_vec <= req_vector;
    end
    if (read_reply_valid) io_pend <= 1'b1;
    if (auto_en && ack_pend) begin
      interrupt_acknowledge_read_valid <= 1'b1;
      interrupt_acknowledge_read_compat <= 1'b1;
      interrupt_acknowledge_read_byte_mask <= 4'h5;
      ack_pend <= 1'b0;
    end else if (auto_en && io_pend) begin
      io_eoi_valid <= 1'b1;
      io_pend <= 1'b0;
    end else if (auto_en && eoi_pend) begin
      eoi_valid <= 1'b1;
      eoi_vector <= eoi_vec;
      eoi_pend <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [verif/lpic_top_tb.sv]
// Self-checking testbench for the legacy interrupt controller top level.
`timescale 1ns/1ps
`default_nettype none
module lpic_top_tb;
  logic clk = 1'b0;
  logic srst, ext_irq, cfg_wr, mm_wr, mm_rd, mm_hi, auto_en, got;
  logic [7:0] leg_irq;
  logic [63:0] cfg_wdata, cfg_rdata;
  logic [31:0] mm_wdata, mm_rdata, rd, read_reply_data, req_dest;
  logic link_clk, interrupt_acknowledge_read_valid, interrupt_acknowledge_read_compat, eoi_valid, io_eoi_valid, read_reply_valid;
  logic req_valid, req_level, req_dest_mode;
  logic [3:0] interrupt_acknowledge_read_byte_mask, req_msg_type;
  logic [7:0] eoi_vector, req_vector, req_ext_addr;
  logic [3:0] type_exp [8] = '{4'h0, 4'h1, 4'h2, 4'h0, 4'h3, 4'h4, 4'h0, 4'h6};
  int n_fail = 0;
  int check_count = 0;

  always #20 clk = ~clk;

  lpic_top i_dut (.clk, .srst, .link_clk, .leg_irq, .leg_vector_base(8'h40), .leg_dest(8'h21), .ext_irq,
    .interrupt_acknowledge_read_valid, .interrupt_acknowledge_read_compat, .interrupt_acknowledge_read_byte_mask, .eoi_valid, .eoi_vector, .io_eoi_valid, .read_reply_valid,
    .read_reply_data, .req_valid, .req_msg_type, .req_level, .req_dest_mode, .req_dest, .req_vector, .req_ext_addr,
    .cfg_wr, .cfg_wdata, .cfg_rdata, .mm_wr, .mm_rd, .mm_hi, .mm_wdata, .mm_rdata);
  lpic_host_model i_host (.auto_en, .req_valid, .req_msg_type, .req_level, .req_vector, .read_reply_valid,
    .link_clk, .interrupt_acknowledge_read_valid, .interrupt_acknowledge_read_compat, .interrupt_acknowledge_read_byte_mask, .eoi_valid, .eoi_vector, .io_eoi_valid);

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic mm_access(input logic wr, input logic hi, input logic [31:0] d);
    @(posedge clk);
    mm_wr <= wr;
    mm_rd <= !wr;
    mm_hi <= hi;
    mm_wdata <= d;
    @(posedge clk);
    mm_wr <= 1'b0;
    mm_rd <= 1'b0;
    #1;
    rd = mm_rdata;
  endtask

  task automatic cfg_write(input logic [63:0] d);
    @(posedge clk);
    cfg_wr <= 1'b1;
    cfg_wdata <= d;
    @(posedge clk);
    cfg_wr <= 1'b0;
    #1;
  endtask

  // Waits for the current pulse to end, then for the next one, both bounded.
  task automatic wait_ev(input logic sel);
    int n;
    n = 0;
    got = 1'b0;
    while ((sel ? read_reply_valid : req_valid) === 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    n = 0;
    while (!got && n < 200) begin
      @(posedge clk);
      #1;
      got = ((sel ? read_reply_valid : req_valid) === 1'b1);
      n++;
    end
  endtask

  task automatic set_ext(input logic v);
    @(posedge clk);
    ext_irq <= v;
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    {srst, ext_irq, cfg_wr, mm_wr, mm_rd, mm_hi, auto_en} = 7'h41;
    leg_irq = 8'h00;
    cfg_wdata = 64'h0;
    mm_wdata = 32'h0;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    mm_access(1'b0, 1'b0, 32'h0);
    check(64'(rd), 64'h0001_0000);
    mm_access(1'b0, 1'b1, 32'h0);
    check(64'(rd), 64'h0);
    check(cfg_rdata, 64'h0);
    $display("test reset done");
    cfg_write(64'h0000_0000_5A00_0080);
    mm_access(1'b1, 1'b0, 32'hFFFF_FFFF);
    check(cfg_rdata, 64'h0000_0000_5AFF_00FC);
    mm_access(1'b0, 1'b0, 32'h0);
    check(64'(rd), 64'h0001_AFFF);
    cfg_write(64'h0);
    mm_access(1'b1, 1'b1, 32'hA512_3456);
    check(cfg_rdata, 64'h0012_3456_0000_A500);
    mm_access(1'b0, 1'b1, 32'h0);
    check(64'(rd), 64'hA512_3456);
    $display("test registers done");
    @(posedge clk);
    leg_irq[2] <= 1'b1;
    wait_ev(1'b0);
    check({got, req_msg_type, req_level, req_vector, req_dest[7:0]}, {1'b1, 4'h6, 1'b0, 8'h00, 8'h21});
    @(posedge clk);
    leg_irq[5] <= 1'b1;
    wait_ev(1'b1);
    check({got, read_reply_data}, {1'b1, 32'h42});
    wait_ev(1'b0);
    check({got, req_msg_type}, {1'b1, 4'h6});
    wait_ev(1'b1);
    check({got, read_reply_data}, {1'b1, 32'h45});
    @(posedge clk);
    leg_irq <= 8'h00;
    auto_en <= 1'b0;
    $display("test legacy done");
    for (int i = 0; i < 8; i++) begin
      mm_access(1'b1, 1'b0, {16'h0, 4'h0, i[0], i[2:0], 8'h30 + 8'(i)});
      set_ext(1'b1);
      wait_ev(1'b0);
      check(64'(got), 64'(i != 3 && i != 6));
      if (got)
        check({req_msg_type, req_dest_mode, req_vector, req_dest}, {type_exp[i], i[0], 8'h30 + 8'(i), 32'h1234_56A5});
      set_ext(1'b0);
      repeat (8) @(posedge clk);
    end
    $display("test message types done");
    mm_access(1'b1, 1'b0, 32'h0001_0000);
    set_ext(1'b1);
    wait_ev(1'b0);
    check(64'(got), 64'h0);
    mm_access(1'b1, 1'b0, 32'h0000_2055);
    set_ext(1'b0);
    wait_ev(1'b0);
    check({got, req_vector}, {1'b1, 8'h55});
    $display("test mask and polarity done");
    cfg_write(64'h0012_3456_5A00_A500);
    mm_access(1'b1, 1'b0, 32'h0000_8077);
    set_ext(1'b1);
    wait_ev(1'b0);
    check({got, req_level, req_vector, req_ext_addr, req_dest}, {2'b11, 8'h77, 8'h5A, 32'h1234_56A5});
    mm_access(1'b0, 1'b0, 32'h0);
    check(64'(rd), 64'h0000_C077);
    wait_ev(1'b0);
    check(64'(got), 64'h0);
    @(posedge clk);
    auto_en <= 1'b1;
    wait_ev(1'b0);
    check({got, req_vector}, {1'b1, 8'h77});
    set_ext(1'b0);
    $display("test level mode done");
    tally_and_finish();
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    $display("watchdog expired");
    tally_and_finish();
  end
endmodule
`default_nettype wire
